// ==== include/cvam_cfg.svh ====
// cvam_cfg.svh: offsets, field positions, reset values and idle levels of the
// row offset / vertical blanking / address mode block.
// assumes inclusion by bare name from the design files only.
`ifndef CVAM_CFG_SVH
`define CVAM_CFG_SVH

// host I/O ports: index and data, monochrome and colour decode
`define CVAM_PORT_IDX_MONO 16'h03B4
`define CVAM_PORT_DAT_MONO 16'h03B5
`define CVAM_PORT_IDX_COLR 16'h03D4
`define CVAM_PORT_DAT_COLR 16'h03D5

// register indices
`define CVAM_IDX_ROW_OFFSET_LOW 8'h13
`define CVAM_IDX_UNDERLINE_MODE 8'h14
`define CVAM_IDX_VBLANK_START 8'h15
`define CVAM_IDX_VBLANK_END 8'h16
`define CVAM_IDX_CRT_MODE 8'h17

// underline_and_addr_mode fields
`define CVAM_UL_LOC_MSB 4
`define CVAM_UL_CNT4_BIT 5
`define CVAM_UL_DWORD_BIT 6

// crt_mode_control fields
`define CVAM_CM_CNT2_BIT 3
`define CVAM_CM_WRAP_BIT 5
`define CVAM_CM_BYTE_BIT 6
`define CVAM_CM_RUN_BIT 7

// reset values
`define CVAM_RST_ROW_OFFSET 8'h00
`define CVAM_RST_UNDERLINE 8'h00
`define CVAM_RST_VBLANK_START 8'h00
`define CVAM_RST_VBLANK_END 8'h00
`define CVAM_RST_CRT_MODE 8'h00
`define CVAM_RST_INDEX 8'h00

// level of an inactive sync output
`define CVAM_SYNC_IDLE 1'b0

`endif

// ==== include/cvam_pkg.sv ====
// cvam_pkg: types and shared decode of the address mode block.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package cvam_pkg;

    typedef enum logic [2:0] {
        CVAM_BYTE = 3'b001,
        CVAM_WORD = 3'b010,
        CVAM_DWORD = 3'b100
    } cvam_addr_mode_type;

    // doubleword bit overrides the word/byte bit
    function automatic cvam_addr_mode_type cvam_mode_decode(input logic dword,
                                                            input logic byte_sel);
        if (dword) begin
            return CVAM_DWORD;
        end else if (byte_sel) begin
            return CVAM_BYTE;
        end
        return CVAM_WORD;
    endfunction

endpackage

`default_nettype wire

// ==== include/cvam_regs_if.sv ====
// cvam_regs_if: register fields handed from the register file to the logic.
// assumes one clock domain; fields change only on a host write.
`default_nettype none

interface cvam_regs_if;
    logic [7:0] row_offset_low;
    logic [4:0] ul_loc;
    logic cnt4;
    logic dword;
    logic [7:0] vblank_start_low;
    logic [7:0] vblank_end;
    logic cnt2;
    logic wrap_off;
    logic byte_sel;
    logic crtc_run;

    modport regs (
        output row_offset_low, ul_loc, cnt4, dword, vblank_start_low,
        output vblank_end, cnt2, wrap_off, byte_sel, crtc_run
    );
    modport use_side (
        input row_offset_low, ul_loc, cnt4, dword, vblank_start_low,
        input vblank_end, cnt2, wrap_off, byte_sel, crtc_run
    );
endinterface

`default_nettype wire

// ==== verilog/cvam_regfile.sv ====
// cvam_regfile: index/data register file reached over host I/O ports.
// assumes host strobes are one-cycle pulses on i_sys_clk.
`include "cvam_cfg.svh"
`default_nettype none

module cvam_regfile
    import cvam_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // host I/O
    input wire logic i_color_sel,
    input wire logic [15:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    // fields
    cvam_regs_if.regs regs
);
    logic [7:0] index_q;
    logic [7:0] r13_q, r14_q, r15_q, r16_q, r17_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;

    // only the port pair of the current colour setting answers
    wire idx_hit = i_io_addr == (i_color_sel ? `CVAM_PORT_IDX_COLR : `CVAM_PORT_IDX_MONO);
    wire dat_hit = i_io_addr == (i_color_sel ? `CVAM_PORT_DAT_COLR : `CVAM_PORT_DAT_MONO);
    wire dat_wr = i_io_wr && dat_hit;

    always_comb begin
        unique case (index_q)
            `CVAM_IDX_ROW_OFFSET_LOW: rd_mux = r13_q;
            `CVAM_IDX_UNDERLINE_MODE: rd_mux = r14_q;
            `CVAM_IDX_VBLANK_START: rd_mux = r15_q;
            `CVAM_IDX_VBLANK_END: rd_mux = r16_q;
            `CVAM_IDX_CRT_MODE: rd_mux = r17_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            index_q <= `CVAM_RST_INDEX;
            r13_q <= `CVAM_RST_ROW_OFFSET;
            r14_q <= `CVAM_RST_UNDERLINE;
            r15_q <= `CVAM_RST_VBLANK_START;
            r16_q <= `CVAM_RST_VBLANK_END;
            r17_q <= `CVAM_RST_CRT_MODE;
            rdata_q <= 8'h00;
        end else begin
            if (i_io_wr && idx_hit) index_q <= i_io_wdata;
            if (dat_wr && index_q == `CVAM_IDX_ROW_OFFSET_LOW) r13_q <= i_io_wdata;
            if (dat_wr && index_q == `CVAM_IDX_UNDERLINE_MODE) r14_q <= i_io_wdata;
            if (dat_wr && index_q == `CVAM_IDX_VBLANK_START) r15_q <= i_io_wdata;
            if (dat_wr && index_q == `CVAM_IDX_VBLANK_END) r16_q <= i_io_wdata;
            if (dat_wr && index_q == `CVAM_IDX_CRT_MODE) r17_q <= i_io_wdata;
            if (i_io_rd) rdata_q <= idx_hit ? index_q : (dat_hit ? rd_mux : 8'h00);
        end
    end

    assign o_io_rdata = rdata_q;
    assign regs.row_offset_low = r13_q;
    assign regs.ul_loc = r14_q[`CVAM_UL_LOC_MSB:0];
    assign regs.cnt4 = r14_q[`CVAM_UL_CNT4_BIT];
    assign regs.dword = r14_q[`CVAM_UL_DWORD_BIT];
    assign regs.vblank_start_low = r15_q;
    assign regs.vblank_end = r16_q;
    assign regs.cnt2 = r17_q[`CVAM_CM_CNT2_BIT];
    assign regs.wrap_off = r17_q[`CVAM_CM_WRAP_BIT];
    assign regs.byte_sel = r17_q[`CVAM_CM_BYTE_BIT];
    assign regs.crtc_run = r17_q[`CVAM_CM_RUN_BIT];

    chk_index_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        dat_wr && index_q == `CVAM_IDX_VBLANK_END |=> r16_q == $past(i_io_wdata))
        else $error("data port write did not reach indexed register");
endmodule

`default_nettype wire

// ==== verilog/cvam_addr_gen.sv ====
// cvam_addr_gen: memory address counter, its advance interval and the
// byte/word/doubleword reorganisation ahead of the frame buffer decoder.
// assumes i_char_en is a one-cycle character clock enable on i_sys_clk.
`include "cvam_cfg.svh"
`default_nettype none

module cvam_addr_gen
    import cvam_pkg::*;
#(
    parameter int AW = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_char_en,
    input wire logic i_frame_load,
    input wire logic i_row_end,
    input wire logic [AW-1:0] i_start_addr,
    input wire logic [11:0] i_row_offset,
    input wire logic i_dword_units,
    input wire logic i_cnt4,
    input wire logic i_cnt2,
    input wire logic i_wrap_off,
    input wire cvam_addr_mode_type i_mode,
    output logic [AW-1:0] o_fb_addr
);
    logic [AW-1:0] ma_q, base_q, fb_q;
    logic [1:0] div_q;

    // interval: cnt2 gives 2 clocks, cnt4 alone gives 4, else every clock
    wire [1:0] div_top = i_cnt2 ? 2'h1 : (i_cnt4 ? 2'h3 : 2'h0);
    wire step = i_char_en && div_q == div_top;
    // row stride counted in words or doublewords
    wire [AW-1:0] stride = i_dword_units ? AW'({i_row_offset, 2'b00})
                                         : AW'({i_row_offset, 1'b0});
    wire word_wrap = i_mode == CVAM_WORD && !i_wrap_off;
    logic [AW-1:0] shaped;

    always_comb begin
        unique case (i_mode)
            CVAM_BYTE: shaped = ma_q;
            CVAM_WORD: shaped = {ma_q[14:0], i_wrap_off ? ma_q[15] : ma_q[13]};
            CVAM_DWORD: shaped = {ma_q[13:0], ma_q[13], ma_q[12]};
            default: shaped = ma_q;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ma_q <= '0;
            base_q <= '0;
            div_q <= 2'h0;
            fb_q <= '0;
        end else begin
            if (i_frame_load) begin
                ma_q <= i_start_addr;
                base_q <= i_start_addr;
                div_q <= 2'h0;
            end else if (i_row_end) begin
                ma_q <= base_q + stride;
                base_q <= base_q + stride;
                div_q <= 2'h0;
            end else if (i_char_en) begin
                div_q <= step ? 2'h0 : div_q + 2'h1;
                if (step) ma_q <= ma_q + AW'(1);
            end
            // 16KB wrap only in word mode with wrap bit clear
            fb_q <= word_wrap ? {2'b00, shaped[13:0]} : shaped;
        end
    end

    assign o_fb_addr = fb_q;

    chk_word_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        word_wrap |=> o_fb_addr[15:14] == 2'b00)
        else $error("word mode address not wrapped at 16KB");
    chk_div_four: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_cnt4 && !i_cnt2 && step |-> $past(div_q, 1) == 2'h2 || $past(i_char_en) == 1'b0
        || $past(div_q) == 2'h2)
        else $error("count by 4 advanced early");
    chk_byte_pass: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_mode == CVAM_BYTE |=> o_fb_addr == $past(ma_q))
        else $error("byte mode address was shifted");
endmodule

`default_nettype wire

// ==== verilog/cvam_top.sv ====
// cvam_top: row offset, underline, vertical blanking, sync gating and frame
// buffer address modes of the CRT controller.
// assumes timing inputs come from the CRT timing logic on i_sys_clk and the
// host I/O strobes are synchronous one-cycle pulses.
`include "cvam_cfg.svh"
`default_nettype none

// Summary of operation
// - standard mode: offset is the 8-bit register
// - extended mode: 12-bit offset, high nibble extended
// - offset counts words or doublewords per row
// - dword bit wins, else word/byte bit
// - address unshifted, shifted one, shifted two
// - counter advances every 1, 2 or 4
// - underline on selected character box line
// - standard blank start: 10 bits, two overflow bits
// - extended blank start: 12 bits, extended nibble
// - blank end is low eight bits compare
// - software programs start as scan line number
// - controller reset bit low idles both syncs
// - word mode wraps at 16KB unless disabled
// - host uses index then data I/O port
module cvam_top
    import cvam_pkg::*;
#(
    parameter int AW = 16
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // host I/O
    input wire logic i_color_sel,
    input wire logic [15:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    // fields held in neighbouring registers
    input wire logic i_std_ext_sel,
    input wire logic [3:0] i_ext_offset_hi,
    input wire logic [3:0] i_ext_vblank_start_hi,
    input wire logic i_max_scan_b5,
    input wire logic i_overflow_b3,
    input wire logic i_dword_units,
    // timing
    input wire logic i_char_en,
    input wire logic i_frame_load,
    input wire logic i_row_end,
    input wire logic [AW-1:0] i_start_addr,
    input wire logic i_line_pulse,
    input wire logic [11:0] i_scan_line,
    input wire logic [4:0] i_row_scan,
    input wire logic i_text_mode,
    input wire logic i_hsync,
    input wire logic i_vsync,
    // display side
    output logic o_hsync,
    output logic o_vsync,
    output logic o_vblank,
    output logic o_underline,
    output logic [AW-1:0] o_fb_addr,
    output logic [11:0] o_row_offset
);
    cvam_regs_if regs_if ();

    logic [7:0] io_rdata;
    logic [AW-1:0] fb_addr;

    cvam_regfile u_regfile (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_color_sel(i_color_sel),
        .i_io_addr(i_io_addr),
        .i_io_wr(i_io_wr),
        .i_io_rd(i_io_rd),
        .i_io_wdata(i_io_wdata),
        .o_io_rdata(io_rdata),
        .regs(regs_if.regs)
    );

    // row offset width follows the standard/extended select
    wire [11:0] row_offset = i_std_ext_sel
        ? {i_ext_offset_hi, regs_if.row_offset_low}
        : {4'h0, regs_if.row_offset_low};

    wire cvam_addr_mode_type addr_mode = cvam_mode_decode(regs_if.dword,
                                                          regs_if.byte_sel);

    cvam_addr_gen #(
        .AW(AW)
    ) u_addr_gen (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_char_en(i_char_en),
        .i_frame_load(i_frame_load),
        .i_row_end(i_row_end),
        .i_start_addr(i_start_addr),
        .i_row_offset(row_offset),
        .i_dword_units(i_dword_units),
        .i_cnt4(regs_if.cnt4),
        .i_cnt2(regs_if.cnt2),
        .i_wrap_off(regs_if.wrap_off),
        .i_mode(addr_mode),
        .o_fb_addr(fb_addr)
    );

    // blanking start: 10 bits in standard mode, 12 in extended mode
    wire [11:0] vb_start_std = {2'b00, i_max_scan_b5, i_overflow_b3,
                                regs_if.vblank_start_low};
    wire [11:0] vb_start_ext = {i_ext_vblank_start_hi,
                                regs_if.vblank_start_low};
    wire [11:0] vb_start = i_std_ext_sel ? vb_start_ext : vb_start_std;

    // start compares against the scan line number, display begins at line 0
    wire vb_begin = i_line_pulse && i_scan_line == vb_start;
    // end compares only the low eight bits of the scan line number
    wire vb_finish = i_line_pulse && i_scan_line[7:0] == regs_if.vblank_end;

    logic vblank_q;
    logic vblank_d;
    logic hsync_q;
    logic vsync_q;
    logic underline_q;
    logic [11:0] row_offset_q;

    always_comb begin
        vblank_d = vblank_q;
        if (vb_begin) begin
            vblank_d = 1'b1;
        end else if (vblank_q && vb_finish) begin
            vblank_d = 1'b0;
        end
    end

    // underline shows on the selected line of the box, text mode only
    wire underline_d = i_text_mode && i_row_scan == regs_if.ul_loc;

    // controller reset bit forces both syncs idle, nothing else is touched
    wire hsync_d = regs_if.crtc_run ? i_hsync : `CVAM_SYNC_IDLE;
    wire vsync_d = regs_if.crtc_run ? i_vsync : `CVAM_SYNC_IDLE;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vblank_q <= 1'b0;
            hsync_q <= `CVAM_SYNC_IDLE;
            vsync_q <= `CVAM_SYNC_IDLE;
            underline_q <= 1'b0;
            row_offset_q <= 12'h000;
        end else begin
            vblank_q <= vblank_d;
            hsync_q <= hsync_d;
            vsync_q <= vsync_d;
            underline_q <= underline_d;
            row_offset_q <= row_offset;
        end
    end

    assign o_vblank = vblank_q;
    assign o_hsync = hsync_q;
    assign o_vsync = vsync_q;
    assign o_underline = underline_q;
    assign o_row_offset = row_offset_q;
    assign o_fb_addr = fb_addr;
    assign o_io_rdata = io_rdata;

    default clocking cvam_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_offset_std: assert property (
        !i_std_ext_sel && $stable(i_std_ext_sel) && $stable(regs_if.row_offset_low)
        |=> o_row_offset == {4'h0, $past(regs_if.row_offset_low)})
        else $error("standard row offset not the 8-bit register");

    chk_offset_ext: assert property (
        i_std_ext_sel |=> o_row_offset == {$past(i_ext_offset_hi),
                                           $past(regs_if.row_offset_low)})
        else $error("extended row offset not formed from both registers");

    chk_mode_dword: assert property (
        regs_if.dword |-> addr_mode == CVAM_DWORD)
        else $error("doubleword bit did not select doubleword mode");

    chk_mode_word: assert property (
        !regs_if.dword && !regs_if.byte_sel |-> addr_mode == CVAM_WORD)
        else $error("both bits low did not select word mode");

    chk_sync_idle: assert property (
        !regs_if.crtc_run |=> o_hsync == `CVAM_SYNC_IDLE && o_vsync == `CVAM_SYNC_IDLE)
        else $error("sync active while controller held in reset");

    chk_sync_pass: assert property (
        regs_if.crtc_run |=> o_hsync == $past(i_hsync) && o_vsync == $past(i_vsync))
        else $error("sync not passed in normal operation");

    chk_vblank_begin: assert property (
        vb_begin |=> o_vblank)
        else $error("blanking did not begin at the start line");

    chk_vblank_std_msb: assert property (
        !i_std_ext_sel |-> vb_start[9] == i_max_scan_b5 && vb_start[8] == i_overflow_b3
        && vb_start[11:10] == 2'b00)
        else $error("standard blank start high bits misplaced");

    chk_vblank_ext: assert property (
        i_std_ext_sel |-> vb_start[11:8] == i_ext_vblank_start_hi)
        else $error("extended blank start high nibble misplaced");

    chk_vblank_end: assert property (
        o_vblank && !vb_begin && vb_finish |=> !o_vblank)
        else $error("blanking did not end at the end value");

    chk_vblank_hold: assert property (
        o_vblank && !i_line_pulse |=> o_vblank)
        else $error("blanking ended between scan lines");

    chk_underline_line: assert property (
        i_text_mode && i_row_scan == regs_if.ul_loc |=> o_underline)
        else $error("underline missing on selected line");

    chk_underline_gfx: assert property (
        !i_text_mode |=> !o_underline)
        else $error("underline shown outside text mode");

    cov_blank_cycle: cover property (
        vb_begin ##[1:1000] (o_vblank && vb_finish) ##1 !o_vblank);

    cov_sync_forced: cover property (
        regs_if.crtc_run ##1 !regs_if.crtc_run ##1 !regs_if.crtc_run);

    cov_dword_mode: cover property (
        addr_mode == CVAM_DWORD && i_char_en);

    cov_ext_offset: cover property (
        i_std_ext_sel && i_ext_offset_hi != 4'h0 && i_row_end);
endmodule

`default_nettype wire

// ==== tb/cvam_crt_src.sv ====
// cvam_crt_src: scan-line timing source standing in for the CRT timing logic.
// assumes one clock; a scan line lasts four clocks and a frame LAST_LINE+1 lines.
`default_nettype none

module cvam_crt_src #(
    parameter logic [11:0] LAST_LINE = 12'h3FF
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // timing to the block
    output logic o_line_pulse,
    output logic [11:0] o_scan_line,
    output logic o_hsync,
    output logic o_vsync
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase_q;

    // every frame restarts on line zero, where the active area begins
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_q <= 2'h0;
            o_scan_line <= 12'h000;
        end else begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h3) begin
                o_scan_line <= (o_scan_line == LAST_LINE) ? 12'h000 : o_scan_line + 12'h001;
            end
        end
    end

    // pulse marks the first clock of each new line number
    assign o_line_pulse = (phase_q == 2'h0);
    assign o_hsync = phase_q[1] ^ phase_q[0];
    assign o_vsync = &o_scan_line[1:0];
endmodule

`default_nettype wire

// ==== tb/cvam_top_tb.sv ====
// cvam_top_tb: host-side register tasks and display-side checks for cvam_top.
// assumes cvam_crt_src drives the scan-line timing inputs.
`default_nettype none

module cvam_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic color_sel = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
    logic [15:0] io_addr = 16'h0000, start_addr = 16'h0000, fb_addr;
    logic [7:0] io_wdata = 8'h00, io_rdata, rd;
    logic std_ext = 1'b0, ms_b5 = 1'b0, ov_b3 = 1'b0, dw_units = 1'b0;
    logic [3:0] ext_off_hi = 4'h0, ext_vb_hi = 4'h0;
    logic char_en = 1'b0, frame_load = 1'b0, row_end = 1'b0, text_mode = 1'b0;
    logic [4:0] row_scan = 5'h00;
    logic line_pulse, hs, vs, hsync_out, vsync_out, vblank, underline, ph, pv;
    logic [11:0] scan_line, row_offset;
    logic [7:0] pat [5] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C, 8'hEB};
    logic [2:0] modes [5] = '{3'b010, 3'b001, 3'b000, 3'b100, 3'b111};
    logic [11:0] vb_start [3] = '{12'h110, 12'h210, 12'h305};
    logic [11:0] ul_cases [4] = '{12'hBDF, 12'hBFC, 12'h3FE, 12'h801};
    int fail_count = 0;
    int tests_run = 0;

    always #25 clk = ~clk;

    cvam_top #(.AW(16)) dut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_color_sel(color_sel), .i_io_addr(io_addr),
        .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
        .i_std_ext_sel(std_ext), .i_ext_offset_hi(ext_off_hi),
        .i_ext_vblank_start_hi(ext_vb_hi), .i_max_scan_b5(ms_b5), .i_overflow_b3(ov_b3),
        .i_dword_units(dw_units), .i_char_en(char_en), .i_frame_load(frame_load),
        .i_row_end(row_end), .i_start_addr(start_addr), .i_line_pulse(line_pulse),
        .i_scan_line(scan_line), .i_row_scan(row_scan), .i_text_mode(text_mode),
        .i_hsync(hs), .i_vsync(vs), .o_hsync(hsync_out), .o_vsync(vsync_out),
        .o_vblank(vblank), .o_underline(underline), .o_fb_addr(fb_addr),
        .o_row_offset(row_offset)
    );

    cvam_crt_src src (
        .i_sys_clk(clk), .i_rst_n(rst_n), .o_line_pulse(line_pulse),
        .o_scan_line(scan_line), .o_hsync(hs), .o_vsync(vs)
    );

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one-cycle strobe, all qualifiers held across the sampling edge
    task automatic io_cycle(input logic [15:0] addr, input logic wr, input logic [7:0] data);
        step(1);
        io_addr = addr;
        io_wdata = data;
        io_wr = wr;
        io_rd = !wr;
        step(1);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask

    task automatic rd_port(input logic [15:0] addr, output logic [7:0] val);
        io_cycle(addr, 1'b0, 8'h00);
        step(1);
        val = io_rdata;
    endtask

    function automatic logic [15:0] port(input logic data_port);
        return (color_sel ? 16'h03D4 : 16'h03B4) + {15'h0000, data_port};
    endfunction

    task automatic wreg(input logic [7:0] idx, input logic [7:0] val);
        io_cycle(port(1'b0), 1'b1, idx);
        io_cycle(port(1'b1), 1'b1, val);
    endtask

    task automatic rreg(input logic [7:0] idx, output logic [7:0] val);
        io_cycle(port(1'b0), 1'b1, idx);
        rd_port(port(1'b1), val);
    endtask

    task automatic load_frame(input logic [15:0] addr);
        start_addr = addr;
        frame_load = 1'b1;
        step(1);
        frame_load = 1'b0;
    endtask

    task automatic wait_vblank(input logic lvl);
        int n = 0;
        while (vblank !== lvl && n < 9000) begin
            step(1);
            n++;
        end
        check_bit(vblank, lvl, "vblank level reached");
    endtask

    function automatic logic [15:0] reorg(input logic [15:0] ma, input logic [2:0] m);
        return m[2] ? {ma[13:0], ma[13], ma[12]} : m[1] ? ma :
            m[0] ? {ma[14:0], ma[15]} : {2'b00, ma[12:0], ma[13]};
    endfunction

    task automatic end_test(input string name);
        $display("test %s finished, %0d checks so far", name, tests_run);
    endtask

    task automatic close_out();
        $display("checks made %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        step(10);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rreg(8'h13 + i[7:0], rd);
            check_val({8'h00, rd}, 16'h0000, "reset value");
            wreg(8'h13 + i[7:0], pat[i]);
        end
        for (int i = 0; i < 5; i++) begin
            rreg(8'h13 + i[7:0], rd);
            check_val({8'h00, rd}, {8'h00, pat[i]}, "register readback");
        end
        wreg(8'h20, 8'hFF);
        rreg(8'h20, rd);
        check_val({8'h00, rd}, 16'h0000, "unmapped index");
        rd_port(port(1'b0), rd);
        check_val({8'h00, rd}, 16'h0020, "index readback");
        io_cycle(16'h03B4, 1'b1, 8'h13);
        io_cycle(16'h03B5, 1'b1, 8'h00);
        color_sel = 1'b0;
        rreg(8'h13, rd);
        check_val({8'h00, rd}, 16'h00A5, "inactive port pair ignored");
        color_sel = 1'b1;
        end_test("registers");

        ext_off_hi = 4'h3;
        step(3);
        check_val({4'h0, row_offset}, 16'h00A5, "standard offset");
        std_ext = 1'b1;
        step(3);
        check_val({4'h0, row_offset}, 16'h03A5, "extended offset");
        std_ext = 1'b0;
        end_test("row offset");

        // fb addresses: a table of doubleword, word/byte and wrap settings
        for (int i = 0; i < 5; i++) begin
            wreg(8'h14, {1'b0, modes[i][2], 6'h00});
            wreg(8'h17, {1'b1, modes[i][1], modes[i][0], 5'h00});
            load_frame(16'hB6D5);
            step(3);
            check_val(fb_addr, reorg(16'hB6D5, modes[i]), "address mode");
        end
        // eight enables after a frame load, divider at phase 0, give 8, 4, 2 or 4 steps
        for (int i = 0; i < 4; i++) begin
            wreg(8'h14, {2'b00, i[1], 5'h00});
            wreg(8'h17, {4'hE, i[0], 3'h0});
            load_frame(16'h0000);
            char_en = 1'b1;
            step(8);
            char_en = 1'b0;
            step(3);
            check_val(fb_addr, (i == 0) ? 16'h0008 : (i == 2) ? 16'h0002 : 16'h0004,
                      "advance interval");
        end
        wreg(8'h13, 8'h10);
        wreg(8'h14, 8'h00);
        wreg(8'h17, 8'hE0);
        for (int i = 0; i < 2; i++) begin
            dw_units = i[0];
            load_frame(16'h0100);
            row_end = 1'b1;
            step(1);
            row_end = 1'b0;
            step(3);
            check_val(fb_addr, 16'h0100 + (16'h0010 << (1 + i)), "row stride");
        end
        end_test("address modes");

        // case fields: text mode, underline line, row scan, expected
        for (int i = 0; i < 4; i++) begin
            wreg(8'h14, {3'b000, ul_cases[i][10:6]});
            text_mode = ul_cases[i][11];
            row_scan = ul_cases[i][5:1];
            step(3);
            check_bit(underline, ul_cases[i][0], "underline");
        end
        end_test("underline");

        for (int r = 0; r < 2; r++) begin
            wreg(8'h17, {r[0], 7'h60});
            step(2);
            ph = hs;
            pv = vs;
            repeat (16) begin
                step(1);
                check_bit(hsync_out, ph & r[0], "hsync");
                check_bit(vsync_out, pv & r[0], "vsync");
                ph = hs;
                pv = vs;
            end
        end
        end_test("sync gating");

        for (int i = 0; i < 3; i++) begin
            std_ext = (i == 2);
            ms_b5 = (i != 0);
            ov_b3 = (i != 1);
            ext_vb_hi = 4'h3;
            wreg(8'h15, vb_start[i][7:0]);
            wreg(8'h16, vb_start[i][7:0] + 8'h08);
            wait_vblank(1'b0);
            wait_vblank(1'b1);
            check_val({4'h0, scan_line}, {4'h0, vb_start[i]}, "blank start");
            wait_vblank(1'b0);
            check_val({8'h00, scan_line[7:0]}, {8'h00, vb_start[i][7:0] + 8'h08},
                      "blank end");
        end
        end_test("vertical blanking");
        close_out();
    end

    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        $display("wrong value at %0t: tests did not finish in time", $time);
        close_out();
    end
endmodule

`default_nettype wire
